// ===== rtl/atc_pkg.sv
// Package for the acquisition trigger, interrupt and DMA control block
package atc_pkg;
  localparam logic [3:0] ATC_OFS_ROUTING = 4'hF;
  localparam logic [3:0] ATC_OFS_TRIGGER = 4'h2;
  localparam logic [3:0] ATC_OFS_IRQ_DMA = 4'h3;
  localparam logic [3:0] ATC_OFS_CONV_CLR = 4'h8;
  localparam logic [3:0] ATC_OFS_TMR_CLR = 4'hA;
  localparam logic [3:0] ATC_OFS_DMA_CLR = 4'hC;
  localparam logic [15:0] ATC_COUNT_ZERO = 16'h0000;
  localparam logic [15:0] ATC_COUNT_WRAP = 16'hFFFF;

  typedef struct packed {
    logic soft_acq_start;
    logic ext_edge_start_en;
    logic pre_trigger_en;
  } atc_trig_t;
  localparam atc_trig_t ATC_TRIG_RST = '0;

  typedef struct packed {
    logic result_irq_en;
    logic conv_error_irq_en;
    logic timer_irq_en;
    logic dma_done_irq_en;
    logic parallel_port_irq_en;
    logic dma_request_en;
  } atc_irqen_t;
  localparam atc_irqen_t ATC_IRQEN_RST = '0;

  typedef struct packed {
    logic ext_conv_inhibit;
    logic input_config_sel;
    logic conv_pin_drive_dir;
    logic scan_interval_src_sel;
    logic interval_scan_sel;
  } atc_route_t;
  localparam atc_route_t ATC_ROUTE_RST = '0;

  typedef enum logic [1:0] {ATC_IDLE, ATC_ARMED, ATC_RUN} atc_state_t;
endpackage : atc_pkg

// ===== rtl/atc_ctl.sv
// Acquisition trigger, interrupt enable and DMA request control
`timescale 1ns/1ps
module atc_ctl
  import atc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wr_stb,
  input wire logic [3:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic dac_load_sel,
  input wire logic ext_trigger_in,
  input wire logic sample_tc,
  input wire logic fifo_not_empty,
  input wire logic fifo_overflow,
  input wire logic fifo_overrun,
  input wire logic ext_dac_load_in,
  input wire logic timer_out_three,
  input wire logic [15:0] dma_count,
  input wire logic port_c_bit_three,
  input wire logic port_c_bit_zero,
  input wire logic ext_convert_in,
  input wire logic counter_a0_out,
  output logic interval_cnt_en,
  output logic sample_cnt_en,
  output logic acq_running,
  output logic dac_update,
  output logic dma_req,
  output logic host_irq,
  output logic conv_start,
  output logic conv_pin_out,
  output logic conv_pin_oe,
  output atc_route_t route_out
);
  atc_trig_t trig_ff;
  atc_irqen_t irqen_ff;
  atc_route_t route_ff;
  atc_state_t state_ff;
  logic trig_prev_ff, upd_prev_ff, tmr_prev_ff, err_prev_ff;
  logic [15:0] cnt_prev_ff;
  logic err_pend_ff, tmr_pend_ff, tc_pend_ff, dac_update_ff;
  logic trig_rise, upd_rise, tmr_rise, err_rise, cnt_wrap;
  logic wr_trig, wr_conv_clr, wr_tmr_clr, wr_dma_clr;
  atc_trig_t wr_trig_val;
  atc_irqen_t wr_irqen_val;
  atc_route_t wr_route_val;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    return wr_stb && (a == ofs);
  endfunction : hit

  assign wr_trig = hit(wr_addr, ATC_OFS_TRIGGER);
  assign wr_conv_clr = hit(wr_addr, ATC_OFS_CONV_CLR);
  assign wr_tmr_clr = hit(wr_addr, ATC_OFS_TMR_CLR);
  assign wr_dma_clr = hit(wr_addr, ATC_OFS_DMA_CLR);
  assign wr_trig_val = atc_trig_t'(wr_data[$bits(atc_trig_t)-1:0]);
  assign wr_irqen_val = atc_irqen_t'(wr_data[$bits(atc_irqen_t)-1:0]);
  assign wr_route_val = atc_route_t'(wr_data[$bits(atc_route_t)-1:0]);
  assign trig_rise = ext_trigger_in && !trig_prev_ff;
  assign upd_rise = ext_dac_load_in && !upd_prev_ff;
  assign tmr_rise = timer_out_three && !tmr_prev_ff;
  assign err_rise = (fifo_overflow || fifo_overrun) && !err_prev_ff;
  assign cnt_wrap = (cnt_prev_ff == ATC_COUNT_ZERO) &&
                    (dma_count == ATC_COUNT_WRAP);

  // Register writes; only the low bits are kept
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_ff <= ATC_TRIG_RST;
      irqen_ff <= ATC_IRQEN_RST;
      route_ff <= ATC_ROUTE_RST;
    end else if (wr_stb) begin
      if (wr_addr == ATC_OFS_TRIGGER) begin
        trig_ff <= wr_data[$bits(atc_trig_t)-1:0];
      end
      if (wr_addr == ATC_OFS_IRQ_DMA) begin
        irqen_ff <= wr_data[$bits(atc_irqen_t)-1:0];
      end
      if (wr_addr == ATC_OFS_ROUTING) begin
        route_ff <= wr_data[$bits(atc_route_t)-1:0];
      end
    end
  end

  // Edge history
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_prev_ff <= 1'b0;
      upd_prev_ff <= 1'b0;
      tmr_prev_ff <= 1'b0;
      err_prev_ff <= 1'b0;
      cnt_prev_ff <= ATC_COUNT_ZERO;
    end else begin
      trig_prev_ff <= ext_trigger_in;
      upd_prev_ff <= ext_dac_load_in;
      tmr_prev_ff <= timer_out_three;
      err_prev_ff <= fifo_overflow || fifo_overrun;
      cnt_prev_ff <= dma_count;
    end
  end

  // Acquisition sequencer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ATC_IDLE;
    end else begin
      unique case (state_ff)
        ATC_IDLE: begin
          if (trig_ff.ext_edge_start_en && trig_rise) begin
            state_ff <= ATC_RUN;
          end else if (wr_trig && wr_trig_val.soft_acq_start) begin
            state_ff <= wr_trig_val.pre_trigger_en ? ATC_ARMED :
                        ATC_RUN;
          end
        end
        ATC_ARMED: begin
          if (!trig_ff.soft_acq_start || sample_tc) begin
            state_ff <= ATC_IDLE;
          end else if (trig_rise) begin
            state_ff <= ATC_RUN;
          end
        end
        ATC_RUN: begin
          if (sample_tc) begin
            state_ff <= ATC_IDLE;
          end else if (!trig_ff.soft_acq_start &&
                       !trig_ff.ext_edge_start_en) begin
            state_ff <= ATC_IDLE;
          end
        end
        default: begin
          state_ff <= ATC_IDLE;
        end
      endcase
    end
  end

  // Idle after terminal count needs start rewritten; level start would rerun
  assign interval_cnt_en = (state_ff != ATC_IDLE);
  assign sample_cnt_en = (state_ff == ATC_RUN);
  assign acq_running = (state_ff == ATC_RUN);

  // Sticky pending flags, set wins over clear; plus the one-cycle registered DAC update pulse
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      err_pend_ff <= 1'b0;
      tmr_pend_ff <= 1'b0;
      tc_pend_ff <= 1'b0;
      dac_update_ff <= 1'b0;
    end else begin
      if (irqen_ff.conv_error_irq_en && err_rise) begin
        err_pend_ff <= 1'b1;
      end else if (wr_conv_clr) begin
        err_pend_ff <= 1'b0;
      end
      if (irqen_ff.timer_irq_en && (upd_rise || tmr_rise)) begin
        tmr_pend_ff <= 1'b1;
      end else if (wr_tmr_clr) begin
        tmr_pend_ff <= 1'b0;
      end
      if (irqen_ff.dma_done_irq_en && cnt_wrap) begin
        tc_pend_ff <= 1'b1;
      end else if (wr_dma_clr) begin
        tc_pend_ff <= 1'b0;
      end
      dac_update_ff <= dac_load_sel && (upd_rise || tmr_rise);
    end
  end

  assign dac_update = dac_update_ff;
  assign dma_req = irqen_ff.dma_request_en && fifo_not_empty;
  // Error pending kept until cleared but masked while its enable is clear
  assign host_irq = (irqen_ff.result_irq_en && fifo_not_empty) ||
                    (irqen_ff.conv_error_irq_en && err_pend_ff) ||
                    (irqen_ff.timer_irq_en && tmr_pend_ff) ||
                    (irqen_ff.dma_done_irq_en && tc_pend_ff) ||
                    (irqen_ff.parallel_port_irq_en &&
                     (port_c_bit_three || port_c_bit_zero));
  assign conv_start = !route_ff.ext_conv_inhibit &&
                      !route_ff.conv_pin_drive_dir && !ext_convert_in;
  assign conv_pin_oe = route_ff.conv_pin_drive_dir;
  assign conv_pin_out = counter_a0_out;
  assign route_out = route_ff;

  property p_start;
    @(posedge sys_clk) disable iff (!arst_n)
      (state_ff == ATC_IDLE && wr_trig && wr_trig_val.soft_acq_start &&
       !wr_trig_val.pre_trigger_en && !trig_ff.ext_edge_start_en)
      |=> interval_cnt_en && sample_cnt_en;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_tc_end;
    @(posedge sys_clk) disable iff (!arst_n)
      (state_ff == ATC_RUN && sample_tc) |=> !interval_cnt_en;
  endproperty
  a_tc_end: assert property (p_tc_end) else $error("tc no end");
  property p_clr_stop;
    @(posedge sys_clk) disable iff (!arst_n)
      (state_ff == ATC_RUN && !trig_ff.soft_acq_start &&
       !trig_ff.ext_edge_start_en) |=> !interval_cnt_en;
  endproperty
  a_clr_stop: assert property (p_clr_stop) else $error("no stop");
  property p_edge;
    @(posedge sys_clk) disable iff (!arst_n)
      (state_ff == ATC_IDLE && trig_ff.ext_edge_start_en && trig_rise)
      |=> sample_cnt_en;
  endproperty
  a_edge: assert property (p_edge) else $error("edge no start");
  property p_armed;
    @(posedge sys_clk) disable iff (!arst_n)
      (state_ff == ATC_ARMED && !trig_rise) |=> !sample_cnt_en;
  endproperty
  a_armed: assert property (p_armed) else $error("early count");
  property p_tmr_hold;
    @(posedge sys_clk) disable iff (!arst_n)
      (tmr_pend_ff && !wr_tmr_clr) |=> tmr_pend_ff;
  endproperty
  a_tmr_hold: assert property (p_tmr_hold) else $error("tmr lost");
  property p_tmr_set;
    @(posedge sys_clk) disable iff (!arst_n)
      (irqen_ff.timer_irq_en && $rose(timer_out_three)) |=> host_irq;
  endproperty
  a_tmr_set: assert property (p_tmr_set) else $error("tmr no irq");
  property p_dac;
    @(posedge sys_clk) disable iff (!arst_n)
      (dac_load_sel && $rose(ext_dac_load_in)) |=> dac_update;
  endproperty
  a_dac: assert property (p_dac) else $error("no dac load");
  property p_dma;
    @(posedge sys_clk) disable iff (!arst_n)
      dma_req |-> (fifo_not_empty && irqen_ff.dma_request_en);
  endproperty
  a_dma: assert property (p_dma) else $error("bad dma req");
  property p_wrap;
    @(posedge sys_clk) disable iff (!arst_n)
      (irqen_ff.dma_done_irq_en && cnt_wrap) |=>
        tc_pend_ff ##1 (tc_pend_ff || $past(wr_dma_clr));
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap lost");
  property p_inhibit;
    @(posedge sys_clk) disable iff (!arst_n)
      route_ff.ext_conv_inhibit |-> !conv_start;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("conv leak");
  property p_wr_irqen;
    @(posedge sys_clk) disable iff (!arst_n)
      (wr_stb && wr_addr == ATC_OFS_IRQ_DMA) |=>
        irqen_ff == $past(wr_irqen_val);
  endproperty
  a_wr_irqen: assert property (p_wr_irqen) else $error("bad enables");
  property p_wr_route;
    @(posedge sys_clk) disable iff (!arst_n)
      (wr_stb && wr_addr == ATC_OFS_ROUTING) |=>
        route_out == $past(wr_route_val);
  endproperty
  a_wr_route: assert property (p_wr_route) else $error("bad route");
  property p_idle_quiet;
    @(posedge sys_clk) disable iff (!arst_n)
      (state_ff == ATC_IDLE && !wr_trig &&
       !(trig_ff.ext_edge_start_en && trig_rise)) |=> !interval_cnt_en;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("rerun");
  property p_edge_hold;
    @(posedge sys_clk) disable iff (!arst_n)
      (state_ff == ATC_RUN && trig_ff.ext_edge_start_en && !sample_tc)
      |=> acq_running;
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge stop");
  property p_result;
    @(posedge sys_clk) disable iff (!arst_n)
      (irqen_ff.result_irq_en && fifo_not_empty) |-> host_irq;
  endproperty
  a_result: assert property (p_result) else $error("no result irq");
  property p_err_set;
    @(posedge sys_clk) disable iff (!arst_n)
      (irqen_ff.conv_error_irq_en && err_rise &&
       !(wr_stb && wr_addr == ATC_OFS_IRQ_DMA)) |=> host_irq;
  endproperty
  a_err_set: assert property (p_err_set) else $error("no err irq");
  property p_err_clr;
    @(posedge sys_clk) disable iff (!arst_n)
      (wr_conv_clr && !err_rise) |=> !err_pend_ff;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("err kept");
  property p_err_off;
    @(posedge sys_clk) disable iff (!arst_n)
      (!irqen_ff.conv_error_irq_en && !err_pend_ff) |=> !err_pend_ff;
  endproperty
  a_err_off: assert property (p_err_off) else $error("err when off");
  property p_upd_set;
    @(posedge sys_clk) disable iff (!arst_n)
      (irqen_ff.timer_irq_en && $rose(ext_dac_load_in)) |=> tmr_pend_ff;
  endproperty
  a_upd_set: assert property (p_upd_set) else $error("no upd irq");
  property p_tmr_clr;
    @(posedge sys_clk) disable iff (!arst_n)
      (wr_tmr_clr && !(upd_rise || tmr_rise)) |=> !tmr_pend_ff;
  endproperty
  a_tmr_clr: assert property (p_tmr_clr) else $error("tmr kept");
  property p_tmr_off;
    @(posedge sys_clk) disable iff (!arst_n)
      (!irqen_ff.timer_irq_en && !tmr_pend_ff) |=> !tmr_pend_ff;
  endproperty
  a_tmr_off: assert property (p_tmr_off) else $error("tmr when off");
  property p_tc_clr;
    @(posedge sys_clk) disable iff (!arst_n)
      (wr_dma_clr && !cnt_wrap) |=> !tc_pend_ff;
  endproperty
  a_tc_clr: assert property (p_tc_clr) else $error("tc kept");
  property p_pp_on;
    @(posedge sys_clk) disable iff (!arst_n)
      (irqen_ff.parallel_port_irq_en &&
       (port_c_bit_three || port_c_bit_zero)) |-> host_irq;
  endproperty
  a_pp_on: assert property (p_pp_on) else $error("port irq lost");
  property p_pp_off;
    @(posedge sys_clk) disable iff (!arst_n)
      (!irqen_ff.parallel_port_irq_en && !irqen_ff.result_irq_en &&
       !err_pend_ff && !tmr_pend_ff && !tc_pend_ff) |-> !host_irq;
  endproperty
  a_pp_off: assert property (p_pp_off) else $error("port irq leak");
  property p_quiet;
    @(posedge sys_clk) disable iff (!arst_n)
      (irqen_ff == ATC_IRQEN_RST) |-> !host_irq;
  endproperty
  a_quiet: assert property (p_quiet) else $error("irq with none");
  property p_dma_off;
    @(posedge sys_clk) disable iff (!arst_n)
      !irqen_ff.dma_request_en |-> !dma_req;
  endproperty
  a_dma_off: assert property (p_dma_off) else $error("dma when off");
  property p_conv_pass;
    @(posedge sys_clk) disable iff (!arst_n)
      (!route_ff.ext_conv_inhibit && !route_ff.conv_pin_drive_dir &&
       !ext_convert_in) |-> conv_start;
  endproperty
  a_conv_pass: assert property (p_conv_pass) else $error("conv lost");
  property p_drive_block;
    @(posedge sys_clk) disable iff (!arst_n)
      route_ff.conv_pin_drive_dir |-> !conv_start;
  endproperty
  a_drive_block: assert property (p_drive_block) else $error("pin loop");
  property p_dac_off;
    @(posedge sys_clk) disable iff (!arst_n)
      !dac_load_sel |=> !dac_update;
  endproperty
  a_dac_off: assert property (p_dac_off) else $error("dac when off");
  c_pre_trigger_en: cover property (@(posedge sys_clk) disable iff (!arst_n)
    state_ff == ATC_ARMED ##[1:20] state_ff == ATC_RUN);
  c_tc: cover property (@(posedge sys_clk) disable iff (!arst_n)
    state_ff == ATC_RUN ##1 state_ff == ATC_IDLE);
  c_tmr: cover property (@(posedge sys_clk) disable iff (!arst_n)
    tmr_pend_ff ##1 wr_tmr_clr ##1 !tmr_pend_ff);
  c_err: cover property (@(posedge sys_clk) disable iff (!arst_n)
    err_pend_ff ##1 wr_conv_clr ##1 !err_pend_ff);
  c_wrap: cover property (@(posedge sys_clk) disable iff (!arst_n)
    cnt_wrap ##1 tc_pend_ff);
endmodule : atc_ctl

// ===== bench/atc_dma_model.sv
// DMA controller model: transfer count stepping down on each request while run is high
`timescale 1ns/1ps
module atc_dma_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic dma_req,
  output logic [15:0] dma_count
);
  // Gated by run so stray requests never wrap the count
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dma_count <= 16'h0002;
    end else if (run && dma_req) begin
      dma_count <= dma_count - 16'h0001;
    end
  end
endmodule : atc_dma_model

// ===== bench/acq_trigger_irq_dma_ctl_bench.sv
// Self-checking bench for the trigger, interrupt and DMA control block
`timescale 1ns/1ps
module acq_trigger_irq_dma_ctl_bench;
  import atc_pkg::*;
  logic sys_clk = 1'b0, arst_n = 1'b0, wr_stb = 1'b0, dma_run = 1'b0;
  logic [3:0] wr_addr = 4'h0;
  logic [7:0] wr_data = 8'h00, en;
  logic trig = 1'b0, tc = 1'b0, fne = 1'b0, ovf = 1'b0, ovr = 1'b0;
  logic upd = 1'b0, tmr = 1'b0, pc3 = 1'b0, pc0 = 1'b0, cnv = 1'b1;
  logic a0 = 1'b0, ldsel = 1'b1;
  logic [15:0] dma_count;
  logic icnt, scnt, run, dacu, dreq, host_irq, cst, pout, poe;
  atc_route_t route;
  int miscompares = 0, checks = 0, seed = 7, i, n;

  always #10 sys_clk = ~sys_clk;

  atc_ctl dut (.sys_clk(sys_clk), .arst_n(arst_n), .wr_stb(wr_stb),
    .wr_addr(wr_addr), .wr_data(wr_data), .dac_load_sel(ldsel),
    .ext_trigger_in(trig), .sample_tc(tc), .fifo_not_empty(fne),
    .fifo_overflow(ovf), .fifo_overrun(ovr), .ext_dac_load_in(upd),
    .timer_out_three(tmr), .dma_count(dma_count), .port_c_bit_three(pc3),
    .port_c_bit_zero(pc0), .ext_convert_in(cnv), .counter_a0_out(a0),
    .interval_cnt_en(icnt), .sample_cnt_en(scnt), .acq_running(run),
    .dac_update(dacu), .dma_req(dreq), .host_irq(host_irq),
    .conv_start(cst), .conv_pin_out(pout), .conv_pin_oe(poe),
    .route_out(route));
  atc_dma_model dma (.sys_clk(sys_clk), .arst_n(arst_n), .run(dma_run),
    .dma_req(dreq), .dma_count(dma_count));

  function automatic logic exp_irq(input logic [7:0] e, input logic f,
      input logic p3, input logic p0);
    return (e[5] & f) | (e[1] & (p3 | p0));
  endfunction : exp_irq

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick

  // Idle cycle after each write keeps the strobe edge-clean
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wr_stb = 1'b1;
    wr_addr = a;
    wr_data = d;
    tick(1);
    wr_stb = 1'b0;
    tick(1);
  endtask : wr

  task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (6000) @(posedge sys_clk);
    miscompares++;
    summarize();
  end

  initial begin
    tick(8);
    arst_n = 1'b1;
    tick(1);
    chk("route_rst", 16'h0000, route);
    chk("oe_rst", 16'h0000, poe);
    chk("irq_rst", 16'h0000, host_irq);
    for (i = 0; i < 24; i++) begin
      en = (i == 0) ? 8'hC0 : (i == 1) ? 8'hFF : 8'($random(seed));
      {fne, pc3, pc0} = 3'($random(seed));
      wr(ATC_OFS_IRQ_DMA, en);
      chk("irq_mix", 16'(exp_irq(en, fne, pc3, pc0)), host_irq);
      chk("dma_req", 16'(en[0] & fne), dreq);
    end
    fne = 1'b0;
    pc3 = 1'b0;
    pc0 = 1'b0;
    for (i = 0; i < 2; i++) begin
      wr(ATC_OFS_IRQ_DMA, 8'h10);
      {ovr, ovf} = (i == 0) ? 2'b01 : 2'b10;
      tick(2);
      {ovr, ovf} = 2'b00;
      tick(1);
      chk("err_irq", 16'h0001, host_irq);
      wr(ATC_OFS_IRQ_DMA, 8'h00);
      chk("err_mask", 16'h0000, host_irq);
      wr(ATC_OFS_IRQ_DMA, 8'h10);
      chk("err_hold", 16'h0001, host_irq);
      wr(ATC_OFS_CONV_CLR, 8'h00);
      chk("err_clr", 16'h0000, host_irq);
    end
    wr(ATC_OFS_IRQ_DMA, 8'h08);
    tmr = 1'b1;
    n = 0;
    repeat (4) begin
      tick(1);
      n += int'(dacu);
    end
    chk("dac_pulses", 16'h0001, 16'(n));
    chk("tmr_irq", 16'h0001, host_irq);
    wr(ATC_OFS_CONV_CLR, 8'h00);
    chk("tmr_hold", 16'h0001, host_irq);
    wr(ATC_OFS_TMR_CLR, 8'h00);
    chk("tmr_clr", 16'h0000, host_irq);
    tmr = 1'b0;
    wr(ATC_OFS_IRQ_DMA, 8'h00);
    upd = 1'b1;
    tick(3);
    wr(ATC_OFS_IRQ_DMA, 8'h08);
    chk("tmr_ignored", 16'h0000, host_irq);
    upd = 1'b0;
    ldsel = 1'b0;
    tick(1);
    upd = 1'b1;
    n = 0;
    repeat (3) begin
      tick(1);
      n += int'(dacu);
    end
    chk("dac_off", 16'h0000, 16'(n));
    chk("upd_irq", 16'h0001, host_irq);
    wr(ATC_OFS_TMR_CLR, 8'h00);
    chk("upd_clr", 16'h0000, host_irq);
    upd = 1'b0;
    ldsel = 1'b1;
    dma_run = 1'b1;
    fne = 1'b1;
    wr(ATC_OFS_IRQ_DMA, 8'h05);
    n = 0;
    while (host_irq !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    dma_run = 1'b0;
    fne = 1'b0;
    chk("tc_irq", 16'h0001, host_irq);
    wr(ATC_OFS_DMA_CLR, 8'h00);
    chk("tc_clr", 16'h0000, host_irq);
    wr(ATC_OFS_TRIGGER, 8'h04);
    tick(1);
    chk("icnt_sw", 16'h0001, icnt);
    chk("scnt_sw", 16'h0001, scnt);
    wr(ATC_OFS_TRIGGER, 8'h00);
    tick(1);
    chk("icnt_off", 16'h0000, icnt);
    chk("run_off", 16'h0000, run);
    wr(ATC_OFS_TRIGGER, 8'h04);
    tc = 1'b1;
    tick(1);
    tc = 1'b0;
    tick(2);
    chk("run_once", 16'h0000, run);
    // Start and pretrigger kept clear in edge mode
    wr(ATC_OFS_TRIGGER, 8'h02);
    trig = 1'b1;
    tick(3);
    chk("icnt_edge", 16'h0001, icnt);
    chk("run_edge", 16'h0001, run);
    tc = 1'b1;
    tick(1);
    tc = 1'b0;
    tick(2);
    chk("run_tc", 16'h0000, run);
    trig = 1'b0;
    wr(ATC_OFS_TRIGGER, 8'h05);
    tick(1);
    chk("icnt_pre", 16'h0001, icnt);
    chk("scnt_pre", 16'h0000, scnt);
    trig = 1'b1;
    tick(3);
    chk("scnt_trig", 16'h0001, scnt);
    wr(ATC_OFS_TRIGGER, 8'h00);
    a0 = 1'b1;
    cnv = 1'b0;
    wr(ATC_OFS_ROUTING, 8'hE4);
    chk("route_a", 16'h0004, route);
    chk("pin_oe", 16'h0001, poe);
    chk("pin_out", 16'h0001, pout);
    chk("conv_drv", 16'h0000, cst);
    wr(ATC_OFS_ROUTING, 8'h10);
    chk("route_b", 16'h0010, route);
    chk("conv_inh", 16'h0000, cst);
    wr(ATC_OFS_ROUTING, 8'h0B);
    chk("route_c", 16'h000B, route);
    chk("conv_ok", 16'h0001, cst);
    cnv = 1'b1;
    tick(1);
    chk("conv_idle", 16'h0000, cst);
    summarize();
  end
endmodule : acq_trigger_irq_dma_ctl_bench
